// ==== pkg/adaptor_buf_regs.svh ====
// Offsets, field positions, reset values and codes of the adaptor buffer.
// Assumes inclusion by bare name from the design files.
`ifndef ADAPTOR_BUF_REGS_SVH
`define ADAPTOR_BUF_REGS_SVH

// ----------------------------------------------------------------
// Bus target bytes
// ----------------------------------------------------------------
`define TARGET_WRITE_BYTE 8'h80
`define TARGET_READ_BYTE 8'h81

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_PHRASE_LAST 8'h0F
`define OFS_IDENTIFIER 8'h10
`define OFS_ORG_FIRST 8'h11
`define OFS_ORG_LAST 8'h13
`define OFS_PART_FIRST 8'h14
`define OFS_PART_LAST 8'h19
`define OFS_HW_REV 8'h1A
`define OFS_FW_MAJOR 8'h1B
`define OFS_FW_MINOR 8'h1C
`define OFS_MAX_CLOCK 8'h1D
`define OFS_RATE_CAP 8'h1E
`define OFS_SCRATCH 8'h1F
`define OFS_OUT_CTRL 8'h20
`define OFS_PIN_CTRL 8'h21
`define OFS_SPEED_SEL 8'h22

// ----------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------
`define IDENT_DUAL_MODE 8'hA0
`define MAX_CLOCK_HDMI 8'h88
`define MAX_CLOCK_DVI 8'h42
`define RATE_CAP_SLOW 8'h0F
`define RATE_CAP_FAST 8'h1F
`define CTRL_BIT 0
`define SCRATCH_RESET 8'h00
`define OUT_CTRL_RESET 1'b0
`define PIN_CTRL_RESET 1'b0
`define SPEED_1K 8'h01
`define SPEED_5K 8'h02
`define SPEED_10K 8'h04
`define SPEED_100K 8'h08
`define SPEED_400K 8'h10
`define SPEED_RESET 8'h08

`endif

// ==== pkg/adaptor_buf_pkg.sv ====
// Types shared by the adaptor identification buffer.
// Assumes the register header is on the include path.
package adaptor_buf_pkg;
  // Transaction phase of the DDC byte engine, one-hot
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_ADDR = 4'b0010,
    PH_WRITE = 4'b0100,
    PH_READ = 4'b1000
  } phase_e;
endpackage

// ==== pkg/reg_access_if.sv ====
// Register access carrier between the byte engine and the register file.
// Assumes one clock domain; all signals synchronous to clock_i.
`timescale 1ns/1ps
interface reg_access_if;
  logic [7:0] addr;   // Current subaddress
  logic wr_en;        // One-cycle write strobe
  logic [7:0] wdata;  // Write data
  logic [7:0] rdata;  // Read data at addr
  modport engine (output addr, output wr_en, output wdata, input rdata);
  modport regs (input addr, input wr_en, input wdata, output rdata);
endinterface

// ==== rtl/adaptor_reg_file.sv ====
// Register file of the adaptor identification buffer.
// Assumes writes arrive as one-cycle strobes from the byte engine.
`timescale 1ns/1ps
`include "adaptor_buf_regs.svh"
module adaptor_reg_file (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic hdmi_cfg_i,
  input wire logic serial_rate_control_i,
  reg_access_if.regs bus,
  output logic link_output_disable_o,
  output logic consumer_ctrl_passthrough_en_o,
  output logic [7:0] ddc_speed_o
);
  // ----------------------------------------------------------------
  // Constant tables
  // ----------------------------------------------------------------
  // Adaptor phrase, offset 0 in the top byte
  localparam logic [127:0] PHRASE =
    128'h4450_2D48_444D_4920_4144_4150_544F_5204;
  // Identity codes below are arbitrary
  parameter logic [23:0] ORG_IDENT = 24'h00_1234;
  parameter logic [47:0] PART_IDENT = 48'h4142_4344_4546;
  parameter logic [7:0] HW_REV = 8'h00;
  parameter logic [7:0] FW_MAJOR = 8'h00;
  parameter logic [7:0] FW_MINOR = 8'h00;

  // ----------------------------------------------------------------
  // Writable state
  // ----------------------------------------------------------------
  logic [7:0] scratch_r, scratch_nxt;  // Spare byte
  logic out_dis_r, out_dis_nxt;        // Link output disable
  logic pass_r, pass_nxt;              // Passthrough enable
  logic [7:0] speed_r, speed_nxt;      // Speed in use

  // Write decode; undefined speed codes fall back to default
  always_comb begin
    scratch_nxt = scratch_r;
    out_dis_nxt = out_dis_r;
    pass_nxt = pass_r;
    speed_nxt = speed_r;
    if (bus.wr_en) begin
      if (bus.addr == `OFS_SCRATCH) begin
        scratch_nxt = bus.wdata;
      end else if (bus.addr == `OFS_OUT_CTRL) begin
        out_dis_nxt = bus.wdata[`CTRL_BIT];
      end else if (bus.addr == `OFS_PIN_CTRL) begin
        pass_nxt = bus.wdata[`CTRL_BIT];
      end else if (bus.addr == `OFS_SPEED_SEL) begin
        case (bus.wdata)
          `SPEED_1K, `SPEED_5K, `SPEED_10K, `SPEED_100K,
          `SPEED_400K: speed_nxt = bus.wdata;
          default: speed_nxt = `SPEED_RESET;
        endcase
      end
    end
  end

  // Registers; speed powers up at 100 kbps
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scratch_r <= `SCRATCH_RESET;
      out_dis_r <= `OUT_CTRL_RESET;
      pass_r <= `PIN_CTRL_RESET;
      speed_r <= `SPEED_RESET;
    end else begin
      scratch_r <= scratch_nxt;
      out_dis_r <= out_dis_nxt;
      pass_r <= pass_nxt;
      speed_r <= speed_nxt;
    end
  end

  assign link_output_disable_o = out_dis_r;
  assign consumer_ctrl_passthrough_en_o = pass_r;
  // Same register drives the DDC rate for both transports
  assign ddc_speed_o = speed_r;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    bus.rdata = 8'h00;
    if (bus.addr <= `OFS_PHRASE_LAST) begin
      // Phrase only in the HDMI configuration
      bus.rdata = hdmi_cfg_i ? PHRASE[8'd127 - {bus.addr[3:0], 3'b000} -: 8]
                             : 8'h00;
    end else if (bus.addr == `OFS_IDENTIFIER) begin
      bus.rdata = hdmi_cfg_i ? `IDENT_DUAL_MODE : 8'h00;
    end else if (bus.addr <= `OFS_ORG_LAST) begin
      // Most significant byte at the lowest offset
      bus.rdata = ORG_IDENT[8'd23 - 8'(8 * (bus.addr - `OFS_ORG_FIRST))
                            -: 8];
    end else if (bus.addr <= `OFS_PART_LAST) begin
      bus.rdata = PART_IDENT[8'd47 - 8'(8 * (bus.addr - `OFS_PART_FIRST))
                             -: 8];
    end else if (bus.addr == `OFS_HW_REV) begin
      bus.rdata = HW_REV;
    end else if (bus.addr == `OFS_FW_MAJOR) begin
      bus.rdata = FW_MAJOR;
    end else if (bus.addr == `OFS_FW_MINOR) begin
      bus.rdata = FW_MINOR;
    end else if (bus.addr == `OFS_MAX_CLOCK) begin
      bus.rdata = hdmi_cfg_i ? `MAX_CLOCK_HDMI : `MAX_CLOCK_DVI;
    end else if (bus.addr == `OFS_RATE_CAP) begin
      bus.rdata = serial_rate_control_i ? `RATE_CAP_FAST
                                        : `RATE_CAP_SLOW;
    end else if (bus.addr == `OFS_SCRATCH) begin
      bus.rdata = scratch_r;
    end else if (bus.addr == `OFS_OUT_CTRL) begin
      bus.rdata = {7'h00, out_dis_r};
    end else if (bus.addr == `OFS_PIN_CTRL) begin
      bus.rdata = {7'h00, pass_r};
    end else if (bus.addr == `OFS_SPEED_SEL) begin
      bus.rdata = speed_r;
    end
  end
endmodule

// ==== rtl/adaptor_id_buffer.sv ====
// Top of the adaptor identification buffer: DDC byte engine plus registers.
// Assumes a bit-level DDC front end delivers framed bytes synchronously.
`timescale 1ns/1ps
`include "adaptor_buf_regs.svh"
module adaptor_id_buffer (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic output_type_select_addr1_i,
  input wire logic hdmi_cfg_i,
  input wire logic serial_rate_control_i,
  input wire logic ddc_start_i,
  input wire logic ddc_stop_i,
  input wire logic ddc_byte_valid_i,
  input wire logic [7:0] ddc_byte_i,
  input wire logic ddc_byte_req_i,
  output logic ddc_ack_o,
  output logic [7:0] ddc_rdata_o,
  output logic link_output_disable_o,
  output logic consumer_ctrl_passthrough_en_o,
  output logic [7:0] ddc_speed_o
);
  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  adaptor_buf_pkg::phase_e phase_r, phase_nxt;  // Transaction phase
  logic [7:0] ptr_r, ptr_nxt;                   // Subaddress pointer
  logic sub_done_r, sub_done_nxt;               // Pointer loaded this write
  logic ack_r, ack_nxt;                         // Acknowledge pulse
  logic [7:0] rdata_r, rdata_nxt;               // Byte to send
  reg_access_if rbus ();

  // Byte engine; pointer autoincrements and wraps at FFh
  always_comb begin
    phase_nxt = phase_r;
    ptr_nxt = ptr_r;
    sub_done_nxt = sub_done_r;
    ack_nxt = 1'b0;
    rdata_nxt = rdata_r;
    rbus.wr_en = 1'b0;
    rbus.wdata = ddc_byte_i;
    if (ddc_stop_i) begin
      phase_nxt = adaptor_buf_pkg::PH_IDLE;
    end else if (ddc_start_i) begin
      // Repeated start also lands here
      phase_nxt = adaptor_buf_pkg::PH_ADDR;
    end else begin
      case (phase_r)
        adaptor_buf_pkg::PH_ADDR: begin
          if (ddc_byte_valid_i) begin
            // Strap high hides the buffer entirely
            if (output_type_select_addr1_i) begin
              phase_nxt = adaptor_buf_pkg::PH_IDLE;
            end else if (ddc_byte_i == `TARGET_WRITE_BYTE) begin
              ack_nxt = 1'b1;
              sub_done_nxt = 1'b0;
              phase_nxt = adaptor_buf_pkg::PH_WRITE;
            end else if (ddc_byte_i == `TARGET_READ_BYTE) begin
              ack_nxt = 1'b1;
              phase_nxt = adaptor_buf_pkg::PH_READ;
            end else begin
              phase_nxt = adaptor_buf_pkg::PH_IDLE;
            end
          end
        end
        adaptor_buf_pkg::PH_WRITE: begin
          if (ddc_byte_valid_i) begin
            ack_nxt = 1'b1;
            if (!sub_done_r) begin
              ptr_nxt = ddc_byte_i;
              sub_done_nxt = 1'b1;
            end else begin
              rbus.wr_en = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        adaptor_buf_pkg::PH_READ: begin
          if (ddc_byte_req_i) begin
            rdata_nxt = rbus.rdata;
            ptr_nxt = ptr_r + 8'h01;
          end
        end
        default: phase_nxt = adaptor_buf_pkg::PH_IDLE;
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_r <= adaptor_buf_pkg::PH_IDLE;
      ptr_r <= 8'h00;
      sub_done_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      phase_r <= phase_nxt;
      ptr_r <= ptr_nxt;
      sub_done_r <= sub_done_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rbus.addr = ptr_r;
  assign ddc_ack_o = ack_r;
  assign ddc_rdata_o = rdata_r;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  adaptor_reg_file u_regs (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .hdmi_cfg_i(hdmi_cfg_i),
    .serial_rate_control_i(serial_rate_control_i),
    .bus(rbus.regs),
    .link_output_disable_o(link_output_disable_o),
    .consumer_ctrl_passthrough_en_o(consumer_ctrl_passthrough_en_o),
    .ddc_speed_o(ddc_speed_o)
  );
endmodule

// ==== sim/adaptor_id_buffer_asserts.sv ====
// Port-level checks on the adaptor identification buffer.
// Assumes one clock domain; bound to the top at the foot.
`timescale 1ns/1ps
module adaptor_id_buffer_asserts (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic output_type_select_addr1_i,
  input wire logic ddc_byte_valid_i,
  input wire logic ddc_byte_req_i,
  input wire logic ddc_ack_o,
  input wire logic [7:0] ddc_rdata_o,
  input wire logic link_output_disable_o,
  input wire logic consumer_ctrl_passthrough_en_o,
  input wire logic [7:0] ddc_speed_o
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  chk_strap_no_ack: assert property (
    output_type_select_addr1_i && ddc_byte_valid_i |=> !ddc_ack_o)
    else $error("ack while strap high");
  chk_ack_cause: assert property ($rose(ddc_ack_o) |->
    $past(ddc_byte_valid_i)) else $error("ack without byte");
  chk_speed_code: assert property (ddc_speed_o inside
    {8'h01, 8'h02, 8'h04, 8'h08, 8'h10}) else $error("bad speed");
  chk_speed_cause: assert property ($changed(ddc_speed_o) |->
    $past(ddc_byte_valid_i)) else $error("speed moved alone");
  chk_disable_cause: assert property (
    $changed(link_output_disable_o) |-> $past(ddc_byte_valid_i))
    else $error("disable moved alone");
  chk_pass_cause: assert property (
    $changed(consumer_ctrl_passthrough_en_o) |-> $past(ddc_byte_valid_i))
    else $error("passthrough moved alone");
  chk_rdata_cause: assert property ($changed(ddc_rdata_o) |->
    $past(ddc_byte_req_i)) else $error("rdata moved alone");
  chk_reset_vals: assert property ($rose(arst_n_i) |->
    ddc_speed_o == 8'h08 && !link_output_disable_o)
    else $error("bad values after reset");
endmodule
bind adaptor_id_buffer adaptor_id_buffer_asserts adaptor_id_buffer_asserts_i (
  .clock_i, .arst_n_i, .output_type_select_addr1_i, .ddc_byte_valid_i,
  .ddc_byte_req_i, .ddc_ack_o, .ddc_rdata_o, .link_output_disable_o,
  .consumer_ctrl_passthrough_en_o, .ddc_speed_o);

// ==== sim/ddc_host_model.sv ====
// Video source model: frames DDC bytes at falling edges.
// Assumes the byte-level handshake of the buffer, one clock.
`timescale 1ns/1ps
module ddc_host_model (
  input wire logic clock_i,
  input wire logic ddc_ack_o,
  input wire logic [7:0] ddc_rdata_o,
  output logic ddc_start_i,
  output logic ddc_stop_i,
  output logic ddc_byte_valid_i,
  output logic [7:0] ddc_byte_i,
  output logic ddc_byte_req_i
);
  initial begin
    {ddc_start_i, ddc_stop_i, ddc_byte_valid_i, ddc_byte_req_i} = 4'h0;
    ddc_byte_i = 8'h00;
  end
  // Start or stop condition, one cycle
  task automatic frame(input logic stop);
    @(negedge clock_i);
    if (stop) ddc_stop_i = 1'b1;
    else ddc_start_i = 1'b1;
    @(negedge clock_i);
    {ddc_start_i, ddc_stop_i} = 2'b00;
  endtask
  // One byte out; ack seen in the following cycle
  task automatic put(input logic [7:0] b, output logic ok);
    @(negedge clock_i);
    ddc_byte_valid_i = 1'b1;
    ddc_byte_i = b;
    @(negedge clock_i);
    ddc_byte_valid_i = 1'b0;
    ddc_byte_i = ~b; // Released bus shows no stale value
    ok = ddc_ack_o;
  endtask
  // One byte in
  task automatic get(output logic [7:0] d);
    @(negedge clock_i);
    ddc_byte_req_i = 1'b1;
    @(negedge clock_i);
    ddc_byte_req_i = 1'b0;
    @(negedge clock_i);
    d = ddc_rdata_o;
  endtask
endmodule

// ==== sim/adaptor_id_buffer_tb.sv ====
// Self-checking bench for the adaptor identification buffer.
// Assumes the host model and checker are compiled alongside.
`timescale 1ns/1ps
module adaptor_id_buffer_tb;
  logic clock_i = 0, arst_n_i = 0, output_type_select_addr1_i = 0;
  logic hdmi_cfg_i = 1, serial_rate_control_i = 0, a, oc = 0, pc = 0;
  logic ddc_start_i, ddc_stop_i, ddc_byte_valid_i, ddc_byte_req_i;
  logic ddc_ack_o, link_output_disable_o, consumer_ctrl_passthrough_en_o;
  logic [7:0] ddc_byte_i, ddc_rdata_o, ddc_speed_o, scr = 0, spd = 8'h08;
  logic [31:0] seed = 32'h0000_0002;
  int n_errors = 0, num_checks = 0, cyc = 0;
  localparam logic [127:0] PHRASE =
    128'h4450_2D48_444D_4920_4144_4150_544F_5204;
  localparam logic [23:0] ORG = 24'h00_1234; // Arbitrary value
  localparam logic [47:0] PART = 48'h4142_4344_4546; // Arbitrary value
  adaptor_id_buffer adaptor_id_buffer_i (.clock_i, .arst_n_i,
    .output_type_select_addr1_i, .hdmi_cfg_i, .serial_rate_control_i,
    .ddc_start_i, .ddc_stop_i, .ddc_byte_valid_i, .ddc_byte_i,
    .ddc_byte_req_i, .ddc_ack_o, .ddc_rdata_o, .link_output_disable_o,
    .consumer_ctrl_passthrough_en_o, .ddc_speed_o);
  ddc_host_model ddc_host_model_i (.clock_i, .ddc_ack_o, .ddc_rdata_o,
    .ddc_start_i, .ddc_stop_i, .ddc_byte_valid_i, .ddc_byte_i,
    .ddc_byte_req_i);
  always #12.5 clock_i = ~clock_i;
  // Hang guard, far above the few thousand cycles needed
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected byte at an offset, from the live config inputs
  function automatic logic [7:0] exp_b(input logic [7:0] o);
    int k;
    k = o;
    if (k < 16) return hdmi_cfg_i ? 8'(PHRASE >> (8 * (15 - k))) : 8'h00;
    if (k == 16) return hdmi_cfg_i ? 8'hA0 : 8'h00;
    if (k < 20) return 8'(ORG >> (8 * (19 - k)));
    if (k < 26) return 8'(PART >> (8 * (25 - k)));
    case (k)
      29: return hdmi_cfg_i ? 8'h88 : 8'h42;
      30: return serial_rate_control_i ? 8'h1F : 8'h0F;
      31: return scr;
      32: return {7'h00, oc};
      33: return {7'h00, pc};
      34: return spd;
      default: return 8'h00; // Revisions and reserved space
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write transaction: pointer, then optional data byte
  task automatic wr(input logic [7:0] p, d, input bit dat);
    logic k;
    ddc_host_model_i.frame(0);
    ddc_host_model_i.put(8'h80, a);
    ddc_host_model_i.put(p, k);
    if (dat) ddc_host_model_i.put(d, k);
    ddc_host_model_i.frame(1);
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    logic [7:0] d;
    wr(p, 0, 0);
    ddc_host_model_i.frame(0);
    ddc_host_model_i.put(8'h81, a);
    chk(8'(a), 8'h01);
    for (int i = 0; i < n; i++) begin
      ddc_host_model_i.get(d);
      chk(d, exp_b(8'(p + i)));
    end
    ddc_host_model_i.frame(1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock_i);
    arst_n_i = 1;
    chk(ddc_speed_o, 8'h08);
    for (int m = 0; m < 4; m++) begin
      {hdmi_cfg_i, serial_rate_control_i} = 2'(m);
      rd(8'h00, 256);
    end
    $display("identity map done");
    for (int i = 0; i < 28; i++) begin
      logic [7:0] r, v;
      r = 8'(8'h1F + i % 4);
      v = 8'(rnd());
      if (r == 8'h22 && i < 20) v = 8'h01 << (i / 4);
      wr(r, v, 1);
      chk(8'(a), 8'h01);
      if (r == 8'h1F) scr = v;
      else if (r == 8'h20) oc = v[0];
      else if (r == 8'h21) pc = v[0];
      else spd = (v inside {1, 2, 4, 8, 16}) ? v : 8'h08;
      chk(ddc_speed_o, spd);
      chk(8'(link_output_disable_o), 8'(oc));
      chk(8'(consumer_ctrl_passthrough_en_o), 8'(pc));
      rd(r, 1);
    end
    $display("control writes done");
    wr(8'h10, 8'hFF, 1);
    wr(8'h1A, 8'hFF, 1);
    rd(8'h10, 11);
    // Strap drawn at random; first pass always hides the buffer
    for (int i = 0; i < 8; i++) begin
      logic [7:0] v;
      v = 8'(rnd());
      output_type_select_addr1_i = v[0] | (i == 0);
      wr(8'h1F, v, 1);
      chk(8'(a), 8'(!output_type_select_addr1_i));
      if (!output_type_select_addr1_i) scr = v;
    end
    output_type_select_addr1_i = 0;
    ddc_host_model_i.frame(0);
    ddc_host_model_i.put(8'h82, a);
    ddc_host_model_i.frame(1);
    chk(8'(a), 8'h00);
    rd(8'h1F, 1);
    $display("refusals done");
    arst_n_i = 0;
    @(negedge clock_i);
    arst_n_i = 1;
    {scr, spd, oc, pc} = {8'h00, 8'h08, 2'b00};
    rd(8'h1F, 4);
    $display("second reset done");
    stop_test();
  end
endmodule
